// *** dv/slc_tb.sv ***
// self-checking bench for the serial link configuration registers
module testbench
  import slc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, reg_wr, reg_rd, high_speed, rx_class;
  logic        fifo_below_quarter, fifo_busy, serdes_tick, idle_request;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seg_size, seed, v, r;
  logic [15:0] rev_pins, ident_pins, seg_base;
  logic [3:0]  priv_lookup_idx, privilege_ident;
  logic [5:0]  seg_lookup_idx;
  logic [1:0]  lane_mode;
  logic [2:0]  bus_priority, fabric_priority, p0, p1, e0, e1;
  logic        hs;
  int          fails, checks_done, code;
  int          priv[16];
  int          seg[64];
  // reset view: address and expected word
  logic [7:0]  ra[8] = '{8'h30, 8'h34, 8'h38, 8'h3c, 8'h44, 8'h48, 8'h4c,
                         8'h50};
  logic [31:0] rv[8] = '{0, 0, 0, 0, 32'h07070007, 32'h04000400, 6, 0};
  // lane table: zero, single, quad, idle, then expected mode
  logic [5:0]  lt[8] = '{6'b000010, 6'b001010, 6'b010001, 6'b101100,
                         6'b001110, 6'b010101, 6'b110100, 6'b011010};

  slc_regs #(.WAKE_UNIT_SH(2)) dut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rev_pins(rev_pins),
    .ident_pins(ident_pins), .fifo_below_quarter(fifo_below_quarter),
    .fifo_busy(fifo_busy), .serdes_tick(serdes_tick),
    .idle_request(idle_request), .rx_class(rx_class),
    .priv_lookup_idx(priv_lookup_idx), .privilege_ident(privilege_ident),
    .seg_lookup_idx(seg_lookup_idx), .seg_base(seg_base),
    .seg_size(seg_size), .high_speed(high_speed), .lane_mode(lane_mode),
    .bus_priority(bus_priority), .fabric_priority(fabric_priority));

  always #5 clk = ~clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // code 31 would need 2^32 bytes and wraps to zero on the 32-bit output
  function automatic logic [31:0] sz(input int c);
    if (c < 8)
      return 32'h0;
    return 32'h1 << (c + 1);
  endfunction

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // every bus signal is set once per rising edge, so strobes never double
  task automatic bus(input logic w, input logic rd_s, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= rd_s;
    reg_addr <= a;
    reg_wdata <= d;
  endtask

  // the idle cycle keeps the write strobe one cycle long
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, 1'b1, a, 32'h0);
    bus(1'b0, 1'b0, a, 32'h0);
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic settle(input int n);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic hold(input logic dn, input int n);
    @(posedge clk);
    fifo_below_quarter <= dn;
    fifo_busy <= ~dn;
    repeat (n) @(posedge clk);
    fifo_below_quarter <= 1'b0;
    fifo_busy <= 1'b0;
    settle(10);
    chk("high speed", {31'h0, high_speed}, {31'h0, hs});
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      serdes_tick <= 1'b1;
      @(posedge clk);
      serdes_tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
    settle(6);
    chk("wake", {31'h0, high_speed}, {31'h0, hs});
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #200000;
    fails++;
    end_of_test();
  end

  initial
  begin
    clk = 0; rst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    fifo_below_quarter = 0; fifo_busy = 0; serdes_tick = 0;
    idle_request = 0; rx_class = 0; priv_lookup_idx = 0;
    seg_lookup_idx = 0; seed = 32'h45; hs = 1'b1;
    rev_pins = 16'h0; ident_pins = 16'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    r = xs();
    rev_pins <= r[31:16];
    ident_pins <= r[15:0];
    for (int i = 0; i < 8; i++)
    begin
      rd(ra[i], v);
      chk("rst", v, rv[i]);
    end
    rd(SLC_OFF_CHIP_VER, v);
    chk("version", v, r);
    wr(SLC_OFF_CHIP_VER, ~r);
    rd(SLC_OFF_CHIP_VER, v);
    chk("version ro", v, r);
    wr(SLC_OFF_PRIV_IDX, '1);
    rd(SLC_OFF_PRIV_IDX, v);
    chk("priv idx", v, 32'hf);
    wr(SLC_OFF_SEG_IDX, '1);
    rd(SLC_OFF_SEG_IDX, v);
    chk("seg idx", v, 32'h3f);
    wr(SLC_OFF_LANE_PWR, '1);
    rd(SLC_OFF_LANE_PWR, v);
    chk("lane pwr", v, 32'h0707ff07);
    wr(8'h00, '1);
    rd(8'h00, v);
    chk("unmapped", v, 32'h0);
    $display("test registers done");

    for (int i = 0; i < 16; i++)
    begin
      wr(SLC_OFF_PRIV_IDX, 32'(i));
      r = xs();
      priv[i] = int'(r[3:0]);
      wr(SLC_OFF_PRIV_VAL, r);
    end
    for (int i = 0; i < 64; i++)
    begin
      wr(SLC_OFF_SEG_IDX, 32'(i));
      r = xs();
      if (i < 32)
        r[4:0] = 5'(i);
      seg[i] = int'(r & 32'hffff001f);
      wr(SLC_OFF_SEG_VAL, r);
    end
    for (int i = 15; i >= 0; i--)
    begin
      wr(SLC_OFF_PRIV_IDX, (xs() & 32'hfffffff0) | 32'(i));
      rd(SLC_OFF_PRIV_VAL, v);
      chk("priv val", v, 32'(priv[i]));
    end
    for (int i = 0; i < 64; i++)
    begin
      wr(SLC_OFF_SEG_IDX, 32'(i));
      rd(SLC_OFF_SEG_VAL, v);
      chk("seg val", v, 32'(seg[i]));
      @(posedge clk);
      priv_lookup_idx <= 4'(i);
      seg_lookup_idx <= 6'(i);
      settle(2);
      chk("ident", {28'h0, privilege_ident}, 32'(priv[i % 16]));
      chk("base", {16'h0, seg_base}, 32'(seg[i]) >> 16);
      code = seg[i] & 31;
      chk("size", seg_size, sz(code));
    end
    $display("test tables done");

    repeat (4)
    begin
      r = xs();
      p0 = {1'b0, r[1:0]};
      p1 = {1'b1, r[4:3]};
      e0 = p0 & r[10:8];
      e1 = p1 & r[13:11];
      v = (r & 32'h88ff88ff) | {1'b0, p0, 1'b0, p1, 9'h0, e0, 1'b0, e1, 8'h0};
      wr(SLC_OFF_RX_PRIO, v);
      rd(SLC_OFF_RX_PRIO, r);
      chk("prio reg", r, v & 32'h77007700);
      for (int c = 0; c < 2; c++)
      begin
        @(posedge clk);
        rx_class <= 1'(c);
        settle(2);
        chk("bus pri", 32'(bus_priority), 32'(c ? p1 : p0));
        chk("fab pri", 32'(fabric_priority), 32'(c ? e1 : e0));
      end
    end
    $display("test priority done");

    // short waits stop below the count, long ones cross it with margin
    wr(SLC_OFF_LANE_PWR, 32'h00000006);
    hold(1'b1, 60);
    hold(1'b1, 60);
    hs = 1'b0;
    hold(1'b1, 72);
    hold(1'b0, 60);
    hold(1'b0, 60);
    hs = 1'b1;
    hold(1'b0, 72);
    wr(SLC_OFF_LANE_PWR, 32'h01010006);
    hold(1'b1, 124);
    hs = 1'b0;
    hold(1'b1, 136);
    hold(1'b0, 124);
    hs = 1'b1;
    hold(1'b0, 136);
    hs = 1'b0;
    hold(1'b1, 136);
    tick(20);
    wr(SLC_OFF_LANE_PWR, 32'h01010106);
    tick(6);
    hs = 1'b1;
    tick(4);
    $display("test speed done");

    for (int i = 0; i < 8; i++)
    begin
      wr(SLC_OFF_LANE_PWR,
         {29'h0, lt[i][3], lt[i][4], lt[i][5]} | 32'h01010000);
      @(posedge clk);
      idle_request <= lt[i][2];
      settle(8);
      chk("lanes", {30'h0, lane_mode}, {30'h0, lt[i][1:0]});
      rd(SLC_OFF_LANE_STAT, v);
      chk("lane stat", {30'h0, v[1:0]}, {30'h0, lt[i][1:0]});
    end
    $display("test lanes done");
    end_of_test();
  end
endmodule

// *** verilog/slc_pkg.sv ***
// shared constants for the serial link configuration register group
package slc_pkg;
  localparam int          SLC_AW            = 8;
  localparam logic [7:0]  SLC_OFF_PRIV_IDX  = 8'h30;
  localparam logic [7:0]  SLC_OFF_PRIV_VAL  = 8'h34;
  localparam logic [7:0]  SLC_OFF_SEG_IDX   = 8'h38;
  localparam logic [7:0]  SLC_OFF_SEG_VAL   = 8'h3c;
  localparam logic [7:0]  SLC_OFF_CHIP_VER  = 8'h40;
  localparam logic [7:0]  SLC_OFF_LANE_PWR  = 8'h44;
  localparam logic [7:0]  SLC_OFF_RX_PRIO   = 8'h48;
  localparam logic [7:0]  SLC_OFF_LANE_STAT = 8'h4c;
  // privilege table
  localparam int          SLC_PRIV_IW       = 4;
  localparam int          SLC_PRIV_DW       = 4;
  // segment table
  localparam int          SLC_SEG_IW        = 6;
  localparam int          SLC_SEG_BASE_LSB  = 16;
  localparam int          SLC_SEG_BASE_W    = 16;
  localparam int          SLC_LEN_W         = 5;
  localparam logic [4:0]  SLC_LEN_MIN_CODE  = 5'h08;
  // lane power fields
  localparam int          SLC_DOWN_LSB      = 24;
  localparam int          SLC_UP_LSB        = 16;
  localparam int          SLC_WAKE_LSB      = 8;
  localparam int          SLC_QUAD_BIT      = 2;
  localparam int          SLC_SINGLE_BIT    = 1;
  localparam int          SLC_ZERO_BIT      = 0;
  localparam logic [2:0]  SLC_DELAY_RST     = 3'h7;
  localparam logic [7:0]  SLC_WAKE_RST      = 8'h00;
  localparam int          SLC_QUAL_BASE_SH  = 6;
  localparam int          SLC_WAKE_UNIT_SH  = 16;
  // priority fields
  localparam int          SLC_C0_PRI_LSB    = 28;
  localparam int          SLC_C1_PRI_LSB    = 24;
  localparam int          SLC_C0_FAB_LSB    = 12;
  localparam int          SLC_C1_FAB_LSB    = 8;
  localparam logic [2:0]  SLC_C0_PRI_RST    = 3'h0;
  localparam logic [2:0]  SLC_C1_PRI_RST    = 3'h4;
  // lane modes
  typedef enum logic [1:0] {
    SLC_LANES_ZERO,
    SLC_LANES_ONE,
    SLC_LANES_FOUR
  } slc_lanes_t;

  // byte size of a segment for a length code
  // code 31 needs 2^32 bytes, which wraps to zero on the 32-bit size
  function automatic logic [31:0] slc_seg_size(input logic [4:0] code);
    if (code < SLC_LEN_MIN_CODE)
      return 32'h0000_0000;
    return 32'h0000_0001 << ({1'b0, code} + 6'h01);
  endfunction

  // clocks of qualification for a 3-bit delay code
  function automatic logic [13:0] slc_qual_cycles(input logic [2:0] code);
    return 14'h0001 << (SLC_QUAL_BASE_SH + code);
  endfunction
endpackage

// *** verilog/slc_qual_counter.sv ***
// qualification counter: pulses after a condition holds for a chosen count
module slc_qual_counter
  import slc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cond,
  input  wire logic [2:0] code,
  output logic            done
);
  logic [13:0] cnt_q;
  logic [13:0] target;

  assign target = slc_qual_cycles(code);

  // restart whenever the condition drops before reaching the target
  always_ff @(posedge clk)
  begin
    if (rst || !cond)
      cnt_q <= '0;
    else if (cnt_q < target)
      cnt_q <= cnt_q + 14'h0001;
  end

  assign done = cond && (cnt_q + 14'h0001 == target);
endmodule

// *** verilog/slc_regs.sv ***
// serial link configuration registers: tables, version, power, priority
// Summary of operation
// - reserved bits read zero and ignore writes.
// - 4-bit privilege index picks the privilege table entry.
// - privilege value reads/writes only the indexed 4-bit entry.
// - 6-bit segment index picks the segment table entry.
// - segment value: base in bits 31-16, length code in bits 4-0.
// - length codes 0-7 give size zero; code 8 gives 0x200 bytes.
// - chip version is read-only: revision pins high, ident pins low.
// - downshift after FIFO below quarter rate 64<<code cycles; reset 7.
// - upshift after FIFO busy 64<<code cycles; code resets to 7.
// - wake interval zero disables; else (value+1)*65536 ticks; reset 0.
// - wake expiry forces full speed; other full speed restarts timer.
// - bit 2 enables four-lane operation; resets to one.
// - bit 1 enables single-lane operation; resets to one.
// - both clear means four lanes; both set means dynamic choice.
// - bit 0 allows power down to zero lanes; else stay on; resets one.
// - class 0 highest priority, class 1 lower, each from its fields.
// - fabric priority arbitrates the fabric; ordinary one orders endpoint.
// - class 1 priority resets to 4, class 0 to 0; 3-bit fields.
//
// Our own choice: the address-and-strobe port.
module slc_regs
  import slc_pkg::*;
#(
  parameter int WAKE_UNIT_SH = SLC_WAKE_UNIT_SH
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [SLC_AW-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic [15:0]       rev_pins,
  input  wire logic [15:0]       ident_pins,
  input  wire logic              fifo_below_quarter,
  input  wire logic              fifo_busy,
  input  wire logic              serdes_tick,
  input  wire logic              idle_request,
  input  wire logic              rx_class,
  input  wire logic [SLC_PRIV_IW-1:0] priv_lookup_idx,
  output logic      [SLC_PRIV_DW-1:0] privilege_ident,
  input  wire logic [SLC_SEG_IW-1:0]  seg_lookup_idx,
  output logic      [15:0]       seg_base,
  output logic      [31:0]       seg_size,
  output logic                   high_speed,
  output logic      [1:0]        lane_mode,
  output logic      [2:0]        bus_priority,
  output logic      [2:0]        fabric_priority
);
  localparam int WAKE_CW = 8 + 24;

  // synchronised pins and fifo status
  logic [15:0] rev_s1_q, rev_s2_q, id_s1_q, id_s2_q;
  logic [1:0]  fifo_s1_q, fifo_s2_q;
  logic [1:0]  tick_s1_q, tick_s2_q;

  logic [SLC_PRIV_IW-1:0] priv_idx_q;
  logic [SLC_SEG_IW-1:0]  seg_idx_q;
  logic [2:0]  downshift_delay_code, upshift_delay_code;
  logic [7:0]  periodic_wake_interval;
  logic        quad_en_q, single_en_q, zero_en_q;
  logic [2:0]  class0_priority, class1_priority;
  logic [2:0]  class0_fabric_priority, class1_fabric_priority;
  logic        high_speed_q;
  slc_lanes_t  lanes_q, lanes_d;
  logic [WAKE_CW-1:0] wake_cnt_q;
  logic        wake_fire;
  logic        down_done, up_done;
  logic        rd_pend_q;
  logic [7:0]  rd_addr_q;
  logic        wr_priv, wr_seg;
  logic [SLC_PRIV_DW-1:0] priv_rd, priv_lk;
  logic [20:0] seg_rd, seg_lk;
  logic [31:0] rd_mux;

  // pins come from outside the clock domain
  always_ff @(posedge clk)
  begin
    rev_s1_q  <= rev_pins;
    rev_s2_q  <= rev_s1_q;
    id_s1_q   <= ident_pins;
    id_s2_q   <= id_s1_q;
    fifo_s1_q <= {fifo_busy, fifo_below_quarter};
    fifo_s2_q <= fifo_s1_q;
    tick_s1_q <= {idle_request, serdes_tick};
    tick_s2_q <= tick_s1_q;
  end

  // index registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      priv_idx_q <= '0;
      seg_idx_q  <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == SLC_OFF_PRIV_IDX)
        priv_idx_q <= reg_wdata[SLC_PRIV_IW-1:0];
      if (reg_addr == SLC_OFF_SEG_IDX)
        seg_idx_q <= reg_wdata[SLC_SEG_IW-1:0];
    end
  end

  assign wr_priv = reg_wr && (reg_addr == SLC_OFF_PRIV_VAL);
  assign wr_seg  = reg_wr && (reg_addr == SLC_OFF_SEG_VAL);

  // software port and lookup port each get a copy of the table
  slc_table_mem #(.IW(SLC_PRIV_IW), .DW(SLC_PRIV_DW)) u_priv_sw (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_priv),
    .wr_idx  (priv_idx_q),
    .wr_data (reg_wdata[SLC_PRIV_DW-1:0]),
    .rd_idx  (priv_idx_q),
    .rd_data (priv_rd)
  );
  slc_table_mem #(.IW(SLC_PRIV_IW), .DW(SLC_PRIV_DW)) u_priv_lk (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_priv),
    .wr_idx  (priv_idx_q),
    .wr_data (reg_wdata[SLC_PRIV_DW-1:0]),
    .rd_idx  (priv_lookup_idx),
    .rd_data (priv_lk)
  );
  slc_table_mem #(.IW(SLC_SEG_IW), .DW(21)) u_seg_sw (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_seg),
    .wr_idx  (seg_idx_q),
    .wr_data ({reg_wdata[31:SLC_SEG_BASE_LSB], reg_wdata[SLC_LEN_W-1:0]}),
    .rd_idx  (seg_idx_q),
    .rd_data (seg_rd)
  );
  slc_table_mem #(.IW(SLC_SEG_IW), .DW(21)) u_seg_lk (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_seg),
    .wr_idx  (seg_idx_q),
    .wr_data ({reg_wdata[31:SLC_SEG_BASE_LSB], reg_wdata[SLC_LEN_W-1:0]}),
    .rd_idx  (seg_lookup_idx),
    .rd_data (seg_lk)
  );

  assign privilege_ident = priv_lk;
  assign seg_base = seg_lk[20:SLC_LEN_W];

  // size decode is registered so the output comes from a flop
  always_ff @(posedge clk)
  begin
    if (rst)
      seg_size <= '0;
    else
      seg_size <= slc_seg_size(seg_lk[SLC_LEN_W-1:0]);
  end

  // lane power control register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      downshift_delay_code   <= SLC_DELAY_RST;
      upshift_delay_code     <= SLC_DELAY_RST;
      periodic_wake_interval <= SLC_WAKE_RST;
      quad_en_q              <= 1'b1;
      single_en_q            <= 1'b1;
      zero_en_q              <= 1'b1;
    end
    else if (reg_wr && reg_addr == SLC_OFF_LANE_PWR)
    begin
      downshift_delay_code   <= reg_wdata[SLC_DOWN_LSB +: 3];
      upshift_delay_code     <= reg_wdata[SLC_UP_LSB +: 3];
      periodic_wake_interval <= reg_wdata[SLC_WAKE_LSB +: 8];
      quad_en_q              <= reg_wdata[SLC_QUAD_BIT];
      single_en_q            <= reg_wdata[SLC_SINGLE_BIT];
      zero_en_q              <= reg_wdata[SLC_ZERO_BIT];
    end
  end

  // priority control register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      class0_priority        <= SLC_C0_PRI_RST;
      class1_priority        <= SLC_C1_PRI_RST;
      class0_fabric_priority <= SLC_C0_PRI_RST;
      class1_fabric_priority <= SLC_C1_PRI_RST;
    end
    else if (reg_wr && reg_addr == SLC_OFF_RX_PRIO)
    begin
      class0_priority        <= reg_wdata[SLC_C0_PRI_LSB +: 3];
      class1_priority        <= reg_wdata[SLC_C1_PRI_LSB +: 3];
      class0_fabric_priority <= reg_wdata[SLC_C0_FAB_LSB +: 3];
      class1_fabric_priority <= reg_wdata[SLC_C1_FAB_LSB +: 3];
    end
  end

  // ordering is not checked: software keeps class 0 numerically lower
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bus_priority    <= SLC_C0_PRI_RST;
      fabric_priority <= SLC_C0_PRI_RST;
    end
    else
    begin
      bus_priority    <= rx_class ? class1_priority : class0_priority;
      fabric_priority <= rx_class ? class1_fabric_priority
                                  : class0_fabric_priority;
    end
  end

  // speed hysteresis
  slc_qual_counter u_down (
    .clk  (clk),
    .rst  (rst),
    .cond (fifo_s2_q[0] && high_speed_q),
    .code (downshift_delay_code),
    .done (down_done)
  );
  slc_qual_counter u_up (
    .clk  (clk),
    .rst  (rst),
    .cond (fifo_s2_q[1] && !high_speed_q),
    .code (upshift_delay_code),
    .done (up_done)
  );

  // periodic wake timer counts serializer ticks
  assign wake_fire = (periodic_wake_interval != 8'h00)
                  && tick_s2_q[0]
                  && (wake_cnt_q + 1'b1 ==
                      (WAKE_CW'(periodic_wake_interval) + 1'b1)
                        << WAKE_UNIT_SH);

  always_ff @(posedge clk)
  begin
    if (rst || high_speed_q || periodic_wake_interval == 8'h00)
      wake_cnt_q <= '0;
    else if (tick_s2_q[0])
      wake_cnt_q <= wake_cnt_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      high_speed_q <= 1'b1;
    else if (wake_fire || up_done)
      high_speed_q <= 1'b1;
    else if (down_done)
      high_speed_q <= 1'b0;
  end

  // lane count selection
  always_comb
  begin
    lanes_d = SLC_LANES_FOUR;
    if (zero_en_q && tick_s2_q[1])
      lanes_d = SLC_LANES_ZERO;
    else if (quad_en_q && single_en_q)
      lanes_d = high_speed_q ? SLC_LANES_FOUR : SLC_LANES_ONE;
    else if (single_en_q)
      lanes_d = SLC_LANES_ONE;
    else
      lanes_d = SLC_LANES_FOUR;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      lanes_q <= SLC_LANES_FOUR;
    else
      lanes_q <= lanes_d;
  end

  assign high_speed = high_speed_q;
  assign lane_mode  = lanes_q;

  // read path: table data arrive one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= '0;
    end
    else
    begin
      rd_pend_q <= reg_rd;
      rd_addr_q <= reg_addr;
    end
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (rd_addr_q)
      SLC_OFF_PRIV_IDX: rd_mux[SLC_PRIV_IW-1:0] = priv_idx_q;
      SLC_OFF_PRIV_VAL: rd_mux[SLC_PRIV_DW-1:0] = priv_rd;
      SLC_OFF_SEG_IDX:  rd_mux[SLC_SEG_IW-1:0] = seg_idx_q;
      SLC_OFF_SEG_VAL:
      begin
        rd_mux[31:SLC_SEG_BASE_LSB] = seg_rd[20:SLC_LEN_W];
        rd_mux[SLC_LEN_W-1:0]       = seg_rd[SLC_LEN_W-1:0];
      end
      SLC_OFF_CHIP_VER: rd_mux = {rev_s2_q, id_s2_q};
      SLC_OFF_LANE_PWR:
      begin
        rd_mux[SLC_DOWN_LSB +: 3] = downshift_delay_code;
        rd_mux[SLC_UP_LSB +: 3]   = upshift_delay_code;
        rd_mux[SLC_WAKE_LSB +: 8] = periodic_wake_interval;
        rd_mux[SLC_QUAD_BIT]      = quad_en_q;
        rd_mux[SLC_SINGLE_BIT]    = single_en_q;
        rd_mux[SLC_ZERO_BIT]      = zero_en_q;
      end
      SLC_OFF_RX_PRIO:
      begin
        rd_mux[SLC_C0_PRI_LSB +: 3] = class0_priority;
        rd_mux[SLC_C1_PRI_LSB +: 3] = class1_priority;
        rd_mux[SLC_C0_FAB_LSB +: 3] = class0_fabric_priority;
        rd_mux[SLC_C1_FAB_LSB +: 3] = class1_fabric_priority;
      end
      SLC_OFF_LANE_STAT: rd_mux = {29'h0, high_speed_q, lanes_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign reg_rdata = rd_pend_q ? rd_mux : 32'h0000_0000;

  // assertions
  reset_vals_a: assert property (@(posedge clk)
    $fell(rst) |-> class1_priority == 3'h4 && downshift_delay_code == 3'h7)
    else $error("bad reset values");
  ver_ro_a: assert property (@(posedge clk) disable iff (rst)
    rd_pend_q && rd_addr_q == SLC_OFF_CHIP_VER
      |-> reg_rdata == {rev_s2_q, id_s2_q})
    else $error("chip version mismatch");
  resv_zero_a: assert property (@(posedge clk) disable iff (rst)
    rd_pend_q && rd_addr_q == SLC_OFF_PRIV_VAL |-> reg_rdata[31:4] == '0)
    else $error("reserved bits not zero");
  seg_resv_a: assert property (@(posedge clk) disable iff (rst)
    rd_pend_q && rd_addr_q == SLC_OFF_SEG_VAL |-> reg_rdata[15:5] == '0)
    else $error("segment reserved bits not zero");
  wake_off_a: assert property (@(posedge clk) disable iff (rst)
    periodic_wake_interval == 8'h00 |-> !wake_fire)
    else $error("wake fired while disabled");
  prio_sel_a: assert property (@(posedge clk) disable iff (rst)
    !rx_class ##1 !rx_class |=> bus_priority == $past(class0_priority))
    else $error("class 0 priority wrong");
  quad_both_a: assert property (@(posedge clk) disable iff (rst)
    !quad_en_q && !single_en_q && !(zero_en_q && tick_s2_q[1])
      |=> lanes_q == SLC_LANES_FOUR)
    else $error("default lane mode wrong");
  zero_off_a: assert property (@(posedge clk) disable iff (rst)
    !zero_en_q |=> lanes_q != SLC_LANES_ZERO)
    else $error("powered down while forbidden");
  up_shift_a: assert property (@(posedge clk) disable iff (rst)
    up_done |=> high_speed_q)
    else $error("no upshift after qualify");
endmodule

// *** verilog/slc_table_mem.sv ***
// small indexed table with registered read data
module slc_table_mem
  import slc_pkg::*;
#(
  parameter int IW = 4,
  parameter int DW = 4
)
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          wr_en,
  input  wire logic [IW-1:0] wr_idx,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [IW-1:0] rd_idx,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem_q [2**IW];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 2**IW; i++)
        mem_q[i] <= '0;
    end
    else if (wr_en)
      mem_q[wr_idx] <= wr_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data <= '0;
    else
      rd_data <= mem_q[rd_idx];
  end
endmodule
